// [inc/kpe_pkg.sv]
// kpe_pkg: constants and types for the keypad entry and trigger output block
// assumes: one 250 MHz clock, all inputs synchronous to it
package kpe_pkg;
    // ************************************************************
    // key codes
    // ************************************************************
    localparam logic [4:0] KEY_D0 = 5'h00; // digits 0..9 are 5'h00..5'h09
    localparam logic [4:0] KEY_D9 = 5'h09;
    localparam logic [4:0] KEY_SIGN = 5'h0A;
    localparam logic [4:0] KEY_INC = 5'h0B;
    localparam logic [4:0] KEY_DEC = 5'h0C;
    localparam logic [4:0] KEY_SHIFT = 5'h0D;
    localparam logic [4:0] KEY_ENTER = 5'h0E;
    localparam logic [4:0] KEY_CANCEL = 5'h0F;
    localparam logic [4:0] KEY_RIGHT = 5'h10;
    localparam logic [4:0] KEY_MANUAL = 5'h11;
    localparam logic [4:0] KEY_BUFFER = 5'h12;
    localparam logic [4:0] KEY_MENU = 5'h13; // rate/waveform/mode/setup menu key
    localparam logic [4:0] KEY_PARAM = 5'h14;
    localparam logic [4:0] KEY_LOCAL = 5'h15;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_DIGITS = 5;
    localparam int NUM_PARAMS = 3;
    localparam logic [2:0] LAST_DIGIT = 3'h4;
    localparam logic [1:0] LAST_PARAM = 2'h2;
    localparam logic [3:0] MENU_LAST = 4'h4;
    localparam logic [9:0] BUF_LAST = 10'h3FF;
    // ************************************************************
    // trigger sources and rates
    // ************************************************************
    localparam logic [2:0] SRC_FP = 3'h0;
    localparam logic [2:0] SRC_EXT = 3'h1;
    localparam logic [2:0] SRC_TALK = 3'h2;
    localparam logic [2:0] SRC_GET = 3'h3;
    localparam logic [2:0] SRC_X = 3'h4;
    localparam logic [2:0] RATE_75 = 3'h3; // rates 0..2 slow, 3 and 4 fast
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 250;
    localparam int PULSE_NS = 10000;
    localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
    localparam int INVALID_NS = 16;
    localparam int INVALID_CYC = INVALID_NS * CLK_MHZ / 1000;
    typedef enum logic [2:0] {
        ST_NORMAL, ST_MENU, ST_PARAM, ST_INVALID, ST_BUFPROMPT, ST_BUFVIEW
    } kpe_state_t;
endpackage

// [hw/kpe_top.sv]
// kpe_top: front-panel data key entry and trigger output pulse
// assumes: keys arrive as one-cycle strobes with a code; sequencer gives done pulses
// How it works
// - trigger output low pulse marks completion
// - one-shot mode: pulse after every reading
// - sweep at slow rates: pulse at end
// - sweep at fast rates: pulse after calculations
// - only selected bus command triggers
// - manual key triggers, except in remote
// - buffer view: increment/decrement steps location
// - menus: increment/decrement scroll options
// - shift arms next key, lights indicator
// - second shift press disarms shift
// - unshifted key runs primary function
// - cancel leaves menus, entry, buffer view
// - cursor advances after digit, wraps left
// - cursor-right moves cursor only
// - commit applies all pending edits
// - scroll to next parameter keeps edits pending
// - cancel discards all pending edits
// - range check on scroll and commit
// - invalid returns to rejected parameter
// - zero at buffer prompt selects converter buffer
// - remote locks all keys but local
`timescale 1ns/1ps
module kpe_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic key_valid,
    input wire logic [4:0] key_code,
    input wire logic remote,
    input wire logic sweep_mode,
    input wire logic [2:0] rate_sel,
    input wire logic [2:0] trig_source,
    input wire logic bus_exec,
    input wire logic bus_talk,
    input wire logic bus_get,
    input wire logic reading_done,
    input wire logic sweep_done,
    input wire logic calc_done,
    input wire logic [3:0] param_max,
    output logic trig_out_n,
    output logic trigger,
    output logic shift_led,
    output logic buffer_led,
    output logic [9:0] buf_addr,
    output logic [3:0] menu_index,
    output logic menu_commit,
    output logic invalid_show,
    output logic [2:0] cursor_pos,
    output logic [1:0] param_index,
    output logic [3:0] edit_digit,
    output logic param_commit,
    output logic [59:0] param_active,
    output logic [2:0] disp_mode
);
    // ************************************************************
    // key decode
    // ************************************************************
    kpe_pkg::kpe_state_t state_reg, state_next;
    logic shift_reg;
    logic [3:0] pend [kpe_pkg::NUM_PARAMS][kpe_pkg::NUM_DIGITS];
    logic [3:0] act [kpe_pkg::NUM_PARAMS][kpe_pkg::NUM_DIGITS];
    logic [15:0] inv_cnt_reg;
    logic [15:0] pulse_cnt_reg;
    logic calc_wait_reg;
    wire key_ok = key_valid && (!remote || key_code == kpe_pkg::KEY_LOCAL);
    wire k_digit = key_ok && key_code <= kpe_pkg::KEY_D9;
    wire k_inc = key_ok && key_code == kpe_pkg::KEY_INC;
    wire k_dec = key_ok && key_code == kpe_pkg::KEY_DEC;
    wire k_cancel = key_ok && key_code == kpe_pkg::KEY_CANCEL;
    wire k_enter = key_ok && key_code == kpe_pkg::KEY_ENTER;
    wire k_shift = key_ok && key_code == kpe_pkg::KEY_SHIFT;
    wire k_right = key_ok && key_code == kpe_pkg::KEY_RIGHT;
    wire k_menu = key_ok && key_code == kpe_pkg::KEY_MENU;
    wire k_param = key_ok && key_code == kpe_pkg::KEY_PARAM;
    wire k_buffer = key_ok && key_code == kpe_pkg::KEY_BUFFER;
    // shifted keys fall through to the primary function
    wire k_any_other = key_ok && !k_shift;
    wire in_param = state_reg == kpe_pkg::ST_PARAM;
    wire in_menu = state_reg == kpe_pkg::ST_MENU;
    wire in_bufview = state_reg == kpe_pkg::ST_BUFVIEW;
    wire cur_bad = pend[param_index][0] > param_max;
    // the parameter key steps forward inside its own menu, like increment
    wire p_next = in_param && (k_inc || k_param);
    wire p_step = p_next || (in_param && k_dec);
    wire check = p_step || (in_param && k_enter);
    wire go_bad = check && cur_bad;
    // ************************************************************
    // trigger decode
    // ************************************************************
    wire man_trig = key_ok && key_code == kpe_pkg::KEY_MANUAL;
    wire bus_trig = (trig_source == kpe_pkg::SRC_X && bus_exec)
        || (trig_source == kpe_pkg::SRC_TALK && bus_talk)
        || (trig_source == kpe_pkg::SRC_GET && bus_get);
    wire fast = rate_sel >= kpe_pkg::RATE_75;
    wire calc_arm = sweep_mode && fast && sweep_done;
    wire pulse_hold = pulse_cnt_reg > 16'h0001;
    wire fire_now = (!sweep_mode && reading_done)
        || (sweep_mode && !fast && sweep_done)
        || (calc_wait_reg && calc_done);
    // ************************************************************
    // entry state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            kpe_pkg::ST_NORMAL: begin
                if (k_menu) begin
                    state_next = kpe_pkg::ST_MENU;
                end else if (k_param) begin
                    state_next = kpe_pkg::ST_PARAM;
                end else if (k_buffer) begin
                    state_next = kpe_pkg::ST_BUFPROMPT;
                end
            end
            kpe_pkg::ST_MENU: begin
                if (k_cancel || k_enter) begin
                    state_next = kpe_pkg::ST_NORMAL;
                end
            end
            kpe_pkg::ST_PARAM: begin
                if (k_cancel) begin
                    state_next = kpe_pkg::ST_NORMAL;
                end else if (go_bad) begin
                    state_next = kpe_pkg::ST_INVALID;
                end else if (k_enter) begin
                    state_next = kpe_pkg::ST_NORMAL;
                end
            end
            kpe_pkg::ST_INVALID: begin
                if (inv_cnt_reg == 16'h0000) begin
                    state_next = kpe_pkg::ST_PARAM;
                end
            end
            kpe_pkg::ST_BUFPROMPT: begin
                if (k_cancel) begin
                    state_next = kpe_pkg::ST_NORMAL;
                end else if (k_digit && key_code == kpe_pkg::KEY_D0) begin
                    state_next = kpe_pkg::ST_BUFVIEW;
                end
            end
            kpe_pkg::ST_BUFVIEW: begin
                if (k_cancel) begin
                    state_next = kpe_pkg::ST_NORMAL;
                end
            end
            default: state_next = kpe_pkg::ST_NORMAL;
        endcase
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= kpe_pkg::ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 1'b0;
        end else if (k_shift) begin
            shift_reg <= !shift_reg;
        end else if (k_any_other) begin
            shift_reg <= 1'b0;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            inv_cnt_reg <= 16'h0000;
        end else if (go_bad) begin
            inv_cnt_reg <= 16'(kpe_pkg::INVALID_CYC - 1);
        end else if (inv_cnt_reg != 16'h0000) begin
            inv_cnt_reg <= inv_cnt_reg - 16'h0001;
        end
    end
    // ************************************************************
    // menu and buffer scrolling
    // ************************************************************
    wire menu_up = in_menu && (k_inc || k_menu);
    wire menu_dn = in_menu && k_dec;
    wire [3:0] menu_up_val = menu_index == kpe_pkg::MENU_LAST ? 4'h0 : menu_index + 4'h1;
    wire [3:0] menu_dn_val = menu_index == 4'h0 ? kpe_pkg::MENU_LAST : menu_index - 4'h1;
    wire buf_open = state_reg == kpe_pkg::ST_BUFPROMPT && state_next == kpe_pkg::ST_BUFVIEW;
    wire buf_close = in_bufview && k_cancel;
    wire buf_up = in_bufview && k_inc;
    wire buf_dn = in_bufview && k_dec;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            menu_index <= 4'h0;
            menu_commit <= 1'b0;
        end else begin
            menu_commit <= in_menu && k_enter;
            if (menu_up) begin
                menu_index <= menu_up_val;
            end else if (menu_dn) begin
                menu_index <= menu_dn_val;
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buf_addr <= 10'h000;
            buffer_led <= 1'b0;
        end else if (buf_open) begin
            buf_addr <= 10'h000;
            buffer_led <= 1'b1;
        end else if (buf_close) begin
            buffer_led <= 1'b0;
        end else if (buf_up) begin
            buf_addr <= buf_addr + 10'h001;
        end else if (buf_dn) begin
            buf_addr <= buf_addr - 10'h001;
        end
    end
    // ************************************************************
    // numeric entry with pending and active copies
    // ************************************************************
    wire entering = state_reg == kpe_pkg::ST_NORMAL && state_next == kpe_pkg::ST_PARAM;
    wire p_digit = in_param && k_digit;
    wire p_right = in_param && k_right;
    wire p_move = p_step && !cur_bad;
    wire p_commit = in_param && k_enter && !cur_bad;
    wire [2:0] cursor_adv = cursor_pos == kpe_pkg::LAST_DIGIT ? 3'h0 : cursor_pos + 3'h1;
    wire [1:0] pidx_up = param_index == kpe_pkg::LAST_PARAM ? 2'h0 : param_index + 2'h1;
    wire [1:0] pidx_dn = param_index == 2'h0 ? kpe_pkg::LAST_PARAM : param_index - 2'h1;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cursor_pos <= 3'h0;
            param_index <= 2'h0;
            param_commit <= 1'b0;
        end else begin
            param_commit <= p_commit;
            if (entering) begin
                cursor_pos <= 3'h0;
                param_index <= 2'h0;
            end else if (p_digit || p_right) begin
                cursor_pos <= cursor_adv;
            end else if (p_move) begin
                cursor_pos <= 3'h0;
                param_index <= p_next ? pidx_up : pidx_dn;
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < kpe_pkg::NUM_PARAMS; p++) begin
                for (int d = 0; d < kpe_pkg::NUM_DIGITS; d++) begin
                    pend[p][d] <= 4'h0;
                    act[p][d] <= 4'h0;
                end
            end
        end else if (entering) begin
            pend <= act;
        end else if (p_digit) begin
            pend[param_index][cursor_pos] <= key_code[3:0];
        end else if (p_commit) begin
            act <= pend;
        end
    end
    // ************************************************************
    // trigger acceptance and output pulse
    // ************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trigger <= 1'b0;
        end else begin
            trigger <= man_trig || bus_trig;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            calc_wait_reg <= 1'b0;
        end else if (calc_arm) begin
            calc_wait_reg <= 1'b1;
        end else if (calc_done) begin
            calc_wait_reg <= 1'b0;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt_reg <= 16'h0000;
        end else if (fire_now) begin
            pulse_cnt_reg <= 16'(kpe_pkg::PULSE_CYC);
        end else if (pulse_cnt_reg != 16'h0000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
        end
    end
    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trig_out_n <= 1'b1;
        end else begin
            trig_out_n <= !(fire_now || pulse_hold);
        end
    end
    assign shift_led = shift_reg;
    assign invalid_show = state_reg == kpe_pkg::ST_INVALID;
    assign edit_digit = pend[param_index][cursor_pos];
    assign disp_mode = 3'(state_reg);
    for (genvar p = 0; p < kpe_pkg::NUM_PARAMS; p++) begin : g_p
        for (genvar d = 0; d < kpe_pkg::NUM_DIGITS; d++) begin : g_d
            assign param_active[(p * kpe_pkg::NUM_DIGITS + d) * 4 +: 4] = act[p][d];
        end
    end
endmodule // kpe_top

// [bench/kpe_top_asserts.sv]
// kpe_top_asserts: port-level concurrent checks for the keypad entry block
// assumes: bound to kpe_top, one clock domain, async active-high reset
`timescale 1ns/1ps
module kpe_top_asserts (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic key_valid,
    input wire logic [4:0] key_code,
    input wire logic remote,
    input wire logic sweep_mode,
    input wire logic [2:0] rate_sel,
    input wire logic [2:0] trig_source,
    input wire logic bus_get,
    input wire logic reading_done,
    input wire logic sweep_done,
    input wire logic [59:0] param_active,
    input wire logic trig_out_n,
    input wire logic trigger,
    input wire logic shift_led,
    input wire logic [9:0] buf_addr,
    input wire logic invalid_show,
    input wire logic [2:0] cursor_pos,
    input wire logic param_commit,
    input wire logic [2:0] disp_mode
);
    // ************************************************************
    // helpers
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic kv = key_valid && !remote;
    int low_cnt_reg;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) low_cnt_reg <= 0;
        else low_cnt_reg <= trig_out_n ? 0 : low_cnt_reg + 1;
    end
    // ************************************************************
    // assertions
    // ************************************************************
    AST_READ_PULSE: assert property (reading_done && !sweep_mode |=> !trig_out_n)
        else $error("no pulse after reading");
    AST_SLOW_SWEEP: assert property (sweep_done && sweep_mode && rate_sel < kpe_pkg::RATE_75
        |=> !trig_out_n) else $error("no pulse after slow sweep");
    AST_PULSE_MIN: assert property ($rose(trig_out_n) |-> low_cnt_reg >= kpe_pkg::PULSE_CYC)
        else $error("output pulse too short");
    AST_BUS_GET: assert property (bus_get && trig_source == kpe_pkg::SRC_GET |=> trigger)
        else $error("selected bus command ignored");
    AST_MANUAL: assert property (kv && key_code == kpe_pkg::KEY_MANUAL |=> trigger)
        else $error("manual key ignored");
    AST_LOCKOUT: assert property (remote && key_valid && key_code != kpe_pkg::KEY_LOCAL
        && disp_mode != 3'h3 |=> $stable(disp_mode) && $stable(shift_led))
        else $error("key taken in remote");
    AST_SHIFT: assert property (kv && key_code == kpe_pkg::KEY_SHIFT
        |=> shift_led != $past(shift_led)) else $error("shift did not toggle");
    AST_CANCEL: assert property (kv && key_code == kpe_pkg::KEY_CANCEL && disp_mode != 3'h3
        |=> disp_mode == 3'h0 && $stable(param_active) && !param_commit)
        else $error("cancel changed settings");
    AST_CURSOR: assert property (kv && disp_mode == 3'h2 && (key_code <= kpe_pkg::KEY_D9
        || key_code == kpe_pkg::KEY_RIGHT) |=> cursor_pos == (($past(cursor_pos) ==
        kpe_pkg::LAST_DIGIT) ? 3'h0 : $past(cursor_pos) + 3'h1)) else $error("cursor step");
    AST_INVALID: assert property ($rose(invalid_show) |-> invalid_show[*4] ##1
        (!invalid_show && disp_mode == 3'h2)) else $error("invalid display length");
    AST_BUF_STEP: assert property (kv && disp_mode == 3'h5 && key_code == kpe_pkg::KEY_INC
        |=> buf_addr == $past(buf_addr) + 10'h001) else $error("buffer step");
    cover property (reading_done && !sweep_mode);
    cover property ($rose(invalid_show));
    cover property (kv && disp_mode == 3'h5 && key_code == kpe_pkg::KEY_INC);
endmodule // kpe_top_asserts
bind kpe_top kpe_top_asserts u_chk (.*);

// [bench/kpe_panel.sv]
// kpe_panel: operator keypad plus the equipment that receives the output pulse
// assumes: keys are strobed one cycle just after a rising clock edge
`timescale 1ns/1ps
module kpe_panel (
    input wire logic clock,
    input wire logic trig_out_n,
    output logic key_valid,
    output logic [4:0] key_code,
    output int n_pulses
);
    initial begin
        key_valid = 1'b0;
        key_code = 5'h1F;
        n_pulses = 0;
    end
    // receiver acts on the leading, falling edge
    always @(negedge trig_out_n) n_pulses <= n_pulses + 1;
    task automatic press(input logic [4:0] code);
        @(posedge clock) #1;
        key_valid = 1'b1;
        key_code = code;
        @(posedge clock) #1;
        key_valid = 1'b0;
        key_code = ~code;
    endtask
endmodule // kpe_panel

// [bench/kpe_top_tb.sv]
// kpe_top_tb: self-checking bench for the keypad entry and trigger output block
// assumes: kpe_pkg, kpe_top, kpe_panel and the checker are compiled first
`timescale 1ns/1ps
module kpe_top_tb;
    logic clock = 1'b0, sys_rst = 1'b1, remote = 1'b0, sweep_mode = 1'b0;
    logic [2:0] rate_sel = 3'h0, trig_source = 3'h0;
    logic bus_exec = 1'b0, bus_talk = 1'b0, bus_get = 1'b0;
    logic reading_done = 1'b0, sweep_done = 1'b0, calc_done = 1'b0;
    logic [3:0] param_max = 4'h9, menu_index, edit_digit;
    logic key_valid, trig_out_n, trigger, shift_led, buffer_led, menu_commit;
    logic invalid_show, param_commit;
    logic [4:0] key_code;
    logic [9:0] buf_addr;
    logic [2:0] cursor_pos, disp_mode;
    logic [1:0] param_index;
    logic [59:0] param_active;
    int n_pulses, fails = 0, n_checks = 0;
    kpe_panel u_pan (.clock(clock), .trig_out_n(trig_out_n), .key_valid(key_valid),
        .key_code(key_code), .n_pulses(n_pulses));
    kpe_top u_dut (.*);
    initial forever #2 clock = ~clock;
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic key(input logic [4:0] c);
        u_pan.press(c);
    endtask
    task automatic bus(input logic [2:0] b, input logic exp);
        @(posedge clock) #1;
        {bus_exec, bus_talk, bus_get} = b;
        @(posedge clock) #1;
        {bus_exec, bus_talk, bus_get} = 3'h0;
        chk(trigger === exp, "bus trigger");
    endtask
    task automatic evt(input logic [2:0] e, input logic exp);
        int n = 0;
        @(posedge clock) #1;
        {reading_done, sweep_done, calc_done} = e;
        @(posedge clock) #1;
        {reading_done, sweep_done, calc_done} = 3'h0;
        chk(trig_out_n === ~exp, "pulse start");
        while (trig_out_n === 1'b0 && n < 3000) begin
            @(posedge clock) #1;
            n++;
        end
        if (exp) chk(n == kpe_pkg::PULSE_CYC, "pulse width");
    endtask
    task automatic wait_inv();
        int n = 0;
        while (invalid_show === 1'b1 && n < 20) begin
            @(posedge clock) #1;
            n++;
        end
    endtask
    task automatic t_bus();
        for (int s = 0; s < 5; s++) begin
            trig_source = s[2:0];
            bus(3'h4, trig_source == kpe_pkg::SRC_X);
            bus(3'h2, trig_source == kpe_pkg::SRC_TALK);
            bus(3'h1, trig_source == kpe_pkg::SRC_GET);
            key(kpe_pkg::KEY_MANUAL);
            chk(trigger === 1'b1, "manual");
        end
        remote = 1'b1;
        key(kpe_pkg::KEY_MANUAL);
        chk(trigger === 1'b0, "manual in remote");
        key(kpe_pkg::KEY_MENU);
        chk(disp_mode === 3'h0, "menu in remote");
        remote = 1'b0;
    endtask
    task automatic t_trig();
        evt(3'h4, 1'b1);
        evt(3'h2, 1'b0);
        sweep_mode = 1'b1;
        rate_sel = 3'h2;
        evt(3'h4, 1'b0);
        evt(3'h2, 1'b1);
        for (int r = 3; r < 5; r++) begin
            rate_sel = r[2:0];
            evt(3'h2, 1'b0);
            evt(3'h1, 1'b1);
        end
        chk(n_pulses == 4, "pulse count");
        sweep_mode = 1'b0;
    endtask
    task automatic t_shift_buf();
        key(kpe_pkg::KEY_SHIFT);
        chk(shift_led === 1'b1, "shift on");
        key(kpe_pkg::KEY_SHIFT);
        chk(shift_led === 1'b0 && disp_mode === 3'h0, "shift off");
        key(kpe_pkg::KEY_SHIFT);
        key(kpe_pkg::KEY_BUFFER);
        chk(shift_led === 1'b0 && disp_mode === 3'h4, "shift primary");
        key(kpe_pkg::KEY_D0);
        chk(buffer_led === 1'b1 && buf_addr === 10'h000 && disp_mode === 3'h5, "buf");
        key(kpe_pkg::KEY_INC);
        key(kpe_pkg::KEY_INC);
        key(kpe_pkg::KEY_DEC);
        chk(buf_addr === 10'h001, "buf step");
        key(kpe_pkg::KEY_CANCEL);
        chk(disp_mode === 3'h0 && buffer_led === 1'b0, "buf exit");
    endtask
    task automatic t_menu();
        key(kpe_pkg::KEY_MENU);
        key(kpe_pkg::KEY_DEC);
        chk(disp_mode === 3'h1 && menu_index === kpe_pkg::MENU_LAST, "menu wrap");
        key(kpe_pkg::KEY_INC);
        key(kpe_pkg::KEY_INC);
        chk(menu_index === 4'h1, "menu inc");
        key(kpe_pkg::KEY_CANCEL);
        chk(disp_mode === 3'h0 && menu_commit === 1'b0, "menu cancel");
        key(kpe_pkg::KEY_MENU);
        key(kpe_pkg::KEY_ENTER);
        chk(menu_commit === 1'b1 && disp_mode === 3'h0, "menu enter");
    endtask
    task automatic t_param();
        key(kpe_pkg::KEY_PARAM);
        for (int d = 1; d < 6; d++) key(d[4:0]);
        chk(disp_mode === 3'h2 && cursor_pos === 3'h0, "cursor wrap");
        key(kpe_pkg::KEY_RIGHT);
        chk(cursor_pos === 3'h1 && edit_digit === 4'h2, "cursor right");
        key(kpe_pkg::KEY_INC);
        chk(param_index === 2'h1 && param_active === 60'h0, "held");
        key(kpe_pkg::KEY_PARAM);
        chk(param_index === 2'h2 && param_active === 60'h0, "param key scroll");
        key(kpe_pkg::KEY_ENTER);
        chk(param_commit === 1'b1 && param_active[19:0] === 20'h54321, "commit");
        key(kpe_pkg::KEY_PARAM);
        key(kpe_pkg::KEY_D9);
        key(kpe_pkg::KEY_INC);
        key(kpe_pkg::KEY_D9);
        key(kpe_pkg::KEY_CANCEL);
        chk(param_active[39:0] === 40'h0000054321, "discard");
        param_max = 4'h2;
        key(kpe_pkg::KEY_PARAM);
        key(5'h05);
        key(kpe_pkg::KEY_ENTER);
        chk(invalid_show === 1'b1 && param_commit === 1'b0, "range enter");
        wait_inv();
        chk(disp_mode === 3'h2 && param_index === 2'h0, "back");
        key(kpe_pkg::KEY_INC);
        chk(invalid_show === 1'b1, "range scroll");
        wait_inv();
        chk(param_index === 2'h0, "stay");
        key(kpe_pkg::KEY_CANCEL);
        chk(param_active[19:0] === 20'h54321, "unchanged");
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clock);
        #1 sys_rst = 1'b0;
        t_bus();
        t_trig();
        t_shift_buf();
        t_menu();
        t_param();
        wrap_up();
    end
endmodule // kpe_top_tb
